/* verilog/reset_park_test_strap_ctrl.sv */
// Reset sequencer, fast park control and test strap handling.
// Assumes all inputs synchronous to sys_clk; reset is the synchronous system reset.
`timescale 1ns/100ps
`include "rst_park_params.svh"
module reset_park_test_strap_ctrl import rst_park_pkg::*; #(
	parameter int W = `STRAP_WIDTH,
	parameter int STRAP_CYC = `STRAP_DELAY_CYC
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Partner controls
	input wire logic power_on_reset_n,
	input wire logic fast_park_n,
	input wire logic manufacturing_test_enable,
	input wire logic scan_port_reset_n,
	// Test strap pins
	input wire logic [W-1:0] test_strap_pins_in,
	output logic [W-1:0] test_strap_pins_out,
	output logic [W-1:0] test_strap_pins_oe,
	// Internal test output data
	input wire logic [W-1:0] test_out_data,
	// Status towards the rest of the controller
	output logic config_start,
	output logic running,
	output logic test_mode,
	output logic [W-1:0] test_mode_sel,
	output logic park_request,
	output logic fast_park_active,
	output logic config_fault
);
	strap_if #(.W(W)) sif ();
	seq_state_e seq_r;
	seq_state_e seq_nxt;
	park_state_e park_r;
	park_state_e park_nxt;
	logic por_prev_r;
	logic [15:0] cnt_r;
	logic cfg_start_r;
	logic [W-1:0] pins_out_r;
	logic drive_r;
	logic fault_r;
	logic held;
	logic [15:0] since_rel_r;

	// Reset pin low acts as a held condition; system reset too
	assign held = reset | !power_on_reset_n;

	strap_capture #(.W(W)) u_cap (
		.sys_clk(sys_clk),
		.reset(held),
		.pins_in(test_strap_pins_in),
		.sif(sif)
	);

	// Previous level of the reset pin for edge detection.
	// Cleared to the released level: a pin already high after system
	// reset is no edge, so the pin must be seen low first.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			por_prev_r <= 1'b1;
		end else begin
			por_prev_r <= power_on_reset_n;
		end
	end

	// Sequencer next state
	always_comb begin
		seq_nxt = seq_r;
		case (seq_r)
			ST_HELD: begin
				if (power_on_reset_n && !por_prev_r) begin
					seq_nxt = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (cnt_r == 16'(STRAP_CYC - 1)) begin
					seq_nxt = ST_CONFIG;
				end
			end
			ST_CONFIG: seq_nxt = ST_RUN;
			ST_RUN: seq_nxt = ST_RUN;
			default: seq_nxt = ST_HELD;
		endcase
		if (!power_on_reset_n) begin
			seq_nxt = ST_HELD;
		end
	end

	// Sequencer state and delay counter
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			seq_r <= ST_HELD;
			cnt_r <= 16'h0000;
		end else begin
			seq_r <= seq_nxt;
			cnt_r <= (seq_r == ST_WAIT && seq_nxt == ST_WAIT) ? cnt_r + 16'h0001 : 16'h0000;
		end
	end

	// strobe the sample on the last wait cycle
	assign sif.sample = (seq_r == ST_WAIT) && (seq_nxt == ST_CONFIG);
	assign sif.drive = drive_r;

	// Configuration start pulse
	always_ff @(posedge sys_clk) begin
		if (held) begin
			cfg_start_r <= 1'b0;
		end else begin
			cfg_start_r <= power_on_reset_n && !por_prev_r;
		end
	end

	// pins released until sampling is done
	always_ff @(posedge sys_clk) begin
		if (held) begin
			drive_r <= 1'b0;
			pins_out_r <= `STRAP_RESET_VAL;
		end else begin
			drive_r <= drive_r | sif.sample;
			pins_out_r <= test_out_data;
		end
	end

	// park state machine; requires running controller
	always_comb begin
		park_nxt = park_r;
		case (park_r)
			PK_IDLE: if (!fast_park_n && seq_r == ST_RUN) park_nxt = PK_FAST;
			PK_FAST: park_nxt = PK_DONE;
			PK_DONE: if (fast_park_n) park_nxt = PK_IDLE;
			default: park_nxt = PK_IDLE;
		endcase
	end

	// Park state register
	always_ff @(posedge sys_clk) begin
		if (held) begin
			park_r <= PK_IDLE;
		end else begin
			park_r <= park_nxt;
		end
	end

	// scan reset or test enable high flags startup fault; sticky until reset or reset pin low
	always_ff @(posedge sys_clk) begin
		if (held) begin
			fault_r <= 1'b0;
		end else begin
			fault_r <= fault_r | scan_port_reset_n | manufacturing_test_enable;
		end
	end

	assign test_strap_pins_out = drive_r ? pins_out_r : '0;
	assign test_strap_pins_oe = drive_r ? {W{1'b1}} : '0;
	assign config_start = cfg_start_r;
	assign running = (seq_r == ST_RUN) && power_on_reset_n;
	assign test_mode = sif.test_mode;
	assign test_mode_sel = sif.mode;
	assign park_request = (park_r != PK_IDLE) && power_on_reset_n;
	assign fast_park_active = (park_r == PK_FAST) && power_on_reset_n;
	assign config_fault = fault_r;

	// Helper for checks only: cycles since the start edge, saturating.
	// Counting keeps a long strap delay cheap to check.
	always_ff @(posedge sys_clk) begin
		if (held || (seq_r == ST_HELD && por_prev_r)) begin
			since_rel_r <= 16'h0000;
		end else if (since_rel_r != 16'hFFFF) begin
			since_rel_r <= since_rel_r + 16'h0001;
		end
	end

	// Fast park steps: one pulse, then the held request
	sequence s_park_steps;
		fast_park_active ##1 park_request;
	endsequence

	// Start sequence checks
	a_start_edge: assert property (@(posedge sys_clk) disable iff (reset)
		power_on_reset_n && !por_prev_r |=> config_start) else $error("no config start on release");
	a_start_pulse: assert property (@(posedge sys_clk) disable iff (reset)
		config_start |=> !config_start) else $error("config start longer than one cycle");

	// Output and pin checks
	a_quiet_held: assert property (@(posedge sys_clk) disable iff (reset)
		!power_on_reset_n |=> !running && !park_request && !config_start) else $error("output active in reset");
	a_pins_hiz: assert property (@(posedge sys_clk) disable iff (reset)
		!power_on_reset_n |=> test_strap_pins_oe == '0) else $error("pins driven in reset");
	a_strap_delay: assert property (@(posedge sys_clk) disable iff (reset)
		since_rel_r <= 16'(STRAP_CYC) |-> test_strap_pins_oe == '0) else $error("pins driven early");
	a_strap_turn: assert property (@(posedge sys_clk) disable iff (reset)
		since_rel_r == 16'(STRAP_CYC + 1) |-> test_strap_pins_oe == {W{1'b1}}) else $error("pins late");
	a_strap_drive: assert property (@(posedge sys_clk) disable iff (reset)
		sif.sample |=> test_strap_pins_oe == {W{1'b1}}) else $error("pins not driven after sample");
	a_test_sel: assert property (@(posedge sys_clk) disable iff (reset)
		test_mode == (test_mode_sel != '0)) else $error("test mode mismatch");

	// Park, fault and mode checks; a pin drop mid park clears everything
	a_fast_park: assert property (@(posedge sys_clk) disable iff (held)
		!fast_park_n && running && park_r == PK_IDLE |=> s_park_steps)
		else $error("fast park not taken");
	a_park_refused: assert property (@(posedge sys_clk) disable iff (reset)
		!fast_park_n && !running && park_r == PK_IDLE |=> !park_request) else $error("park taken while idle");
	a_fault_flag: assert property (@(posedge sys_clk) disable iff (reset)
		!held && (scan_port_reset_n || manufacturing_test_enable) |=> config_fault)
		else $error("test input misuse not flagged");
	a_mode_stable: assert property (@(posedge sys_clk) disable iff (reset)
		running && $past(running) |-> $stable(test_mode_sel)) else $error("mode changed while running");
endmodule // reset_park_test_strap_ctrl

/* verilog/rst_park_params.svh */
// Constants for the reset, park and test strap controller.
// Assumes a 20 MHz system clock; times in nanoseconds.
`ifndef RST_PARK_PARAMS_SVH
`define RST_PARK_PARAMS_SVH
`define CLK_PERIOD_NS 50
`define STRAP_DELAY_NS 1500
`define STRAP_DELAY_CYC (`STRAP_DELAY_NS / `CLK_PERIOD_NS)
`define STRAP_WIDTH 8
`define STRAP_RESET_VAL 8'h00
`define PARK_SYNC_STAGES 2
`endif

/* verilog/rst_park_pkg.sv */
// Types shared by the reset, park and test strap controller.
// Assumes rst_park_params.svh holds the numeric constants.
package rst_park_pkg;
	typedef enum logic [2:0] {ST_HELD, ST_WAIT, ST_CONFIG, ST_RUN} seq_state_e;
	typedef enum logic [1:0] {PK_IDLE, PK_FAST, PK_DONE} park_state_e;
endpackage

/* verilog/strap_if.sv */
// Carrier between the sequencer and the strap capture module.
// Assumes a single sys_clk domain.
`timescale 1ns/100ps
interface strap_if #(parameter int W = 8);
	logic sample;
	logic drive;
	logic [W-1:0] mode;
	logic test_mode;
	modport ctrl (output sample, output drive, input mode, input test_mode);
	modport cap (input sample, input drive, output mode, output test_mode);
endinterface

/* verilog/strap_capture.sv */
// Captures the test strap pins once after reset and holds the mode.
// Assumes pins are synchronous to sys_clk and reset is synchronous.
`timescale 1ns/100ps
`include "rst_park_params.svh"
module strap_capture import rst_park_pkg::*; #(
	parameter int W = `STRAP_WIDTH
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Strap pins and control
	input wire logic [W-1:0] pins_in,
	strap_if.cap sif
);
	logic [W-1:0] mode_r;
	logic [W-1:0] mode_nxt;

	always_comb begin
		// Never capture once the pins carry our own drive
		mode_nxt = (sif.sample && !sif.drive) ? pins_in : mode_r;
	end

	// Mode register, cleared only by reset
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			mode_r <= `STRAP_RESET_VAL;
		end else begin
			mode_r <= mode_nxt;
		end
	end

	assign sif.mode = mode_r;
	// any high strap selects test mode
	assign sif.test_mode = |mode_r;

	a_mode_hold: assert property (@(posedge sys_clk) disable iff (reset)
		!sif.sample |=> mode_r == $past(mode_r)) else $error("strap mode changed without sample");
endmodule // strap_capture

/* dv/pmic_model.sv */
// Power management side model: drives power-on reset and fast park.
// Assumes the bench calls its tasks; changes land 1 ns after sys_clk rises.
`timescale 1ns/100ps
module pmic_model (
	// Clock
	input wire logic sys_clk,
	// Control outputs
	output logic power_on_reset_n,
	output logic fast_park_n,
	output logic manufacturing_test_enable,
	output logic scan_port_reset_n
);
	// Start with reset held, park idle
	initial begin
		power_on_reset_n = 1'b0;
		fast_park_n = 1'b1;
		manufacturing_test_enable = 1'b0;
		scan_port_reset_n = 1'b0;
	end
	task automatic set_por(input logic v);
		@(posedge sys_clk);
		#1 power_on_reset_n = v;
	endtask
	// misuse, only for the fault check
	task automatic set_test_inputs(input logic te, input logic sr);
		@(posedge sys_clk);
		#1 manufacturing_test_enable = te;
		scan_port_reset_n = sr;
	endtask
	task automatic set_park(input logic v);
		@(posedge sys_clk);
		#1 fast_park_n = v;
	endtask
endmodule // pmic_model

/* dv/test_reset_park_test_strap_ctrl.sv */
// Testbench for the reset, park and test strap controller.
// Assumes a 50 ns clock and a short strap delay for speed.
`timescale 1ns/100ps
module test_reset_park_test_strap_ctrl;
	localparam int SC = 3;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] board = 8'h00;
	logic [7:0] tod = 8'h3C;
	logic [7:0] out, oe, sel;
	wire [7:0] pins_in;
	logic por_n, park_n, mte, scan_n, cs, run, tm, preq, fpa, flt;
	int n_mismatch = 0;
	int n_compared = 0;
	// Pin level: device drive wins, else board pull resistors
	assign pins_in = (oe & out) | (~oe & board);
	// Clock
	always #25 sys_clk = ~sys_clk;
	pmic_model u_pmic_model (.sys_clk(sys_clk), .power_on_reset_n(por_n), .fast_park_n(park_n),
		.manufacturing_test_enable(mte), .scan_port_reset_n(scan_n));
	reset_park_test_strap_ctrl #(.STRAP_CYC(SC)) u_reset_park_test_strap_ctrl (.sys_clk(sys_clk),
		.reset(reset), .power_on_reset_n(por_n), .fast_park_n(park_n), .manufacturing_test_enable(mte),
		.scan_port_reset_n(scan_n), .test_strap_pins_in(pins_in), .test_strap_pins_out(out),
		.test_strap_pins_oe(oe), .test_out_data(tod), .config_start(cs), .running(run), .test_mode(tm),
		.test_mode_sel(sel), .park_request(preq), .fast_park_active(fpa), .config_fault(flt));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Settle, then sample; drives land 1 ns after an edge, never beside a sample
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic power_down;
		u_pmic_model.set_por(1'b0);
		step(1);
		check(oe, 8'h00);
		check({3'h0, cs, run, fpa, preq, flt}, 8'h00);
	endtask
	task automatic power_up(input logic [7:0] s);
		board = s;
		u_pmic_model.set_por(1'b1);
		step(1);
		check({7'h00, cs}, 8'h01);
		for (int k = 2; k <= SC; k++) begin
			step(1);
			check(oe, 8'h00);
		end
		step(1);
		check(oe, 8'hFF);
		check(out, tod);
		step(1);
		check({7'h00, run}, 8'h01);
		check(sel, s);
		check({7'h00, tm}, {7'h00, |s});
		board = ~s;
		tod = ~tod;
		step(3);
		check(sel, s);
		check(out, tod);
	endtask
	task automatic park_test(input logic live);
		u_pmic_model.set_park(1'b0);
		step(1);
		check({6'h00, fpa, preq}, {6'h00, live, live});
		step(1);
		check({6'h00, fpa, preq}, {7'h00, live});
		u_pmic_model.set_park(1'b1);
		step(2);
		check({6'h00, fpa, preq}, 8'h00);
	endtask
	task automatic fault_test(input logic te, input logic sr);
		u_pmic_model.set_test_inputs(te, sr);
		step(1);
		check({7'h00, flt}, 8'h01);
		u_pmic_model.set_test_inputs(1'b0, 1'b0);
		step(1);
		check({7'h00, flt}, 8'h01);
	endtask
	task automatic report_and_stop;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Main sequence: reset, ignored park, two power-ups
	initial begin
		repeat (8) @(posedge sys_clk);
		#1 reset = 1'b0;
		step(2);
		power_down();
		park_test(1'b0);
		power_up(8'h00);
		park_test(1'b1);
		fault_test(1'b0, 1'b1);
		power_down();
		power_up(8'hA5);
		fault_test(1'b1, 1'b0);
		power_down();
		report_and_stop();
	end
	// Hang guard: a run this long counts as a mismatch
	initial begin
		#1000000;
		n_mismatch++;
		report_and_stop();
	end
endmodule // test_reset_park_test_strap_ctrl
